// ### verilog/hbp_map.svh
// Constants for the ISA/EISA host bus port
`ifndef HBP_MAP_SVH
`define HBP_MAP_SVH
`define HBP_ISA_DATA_W      16
`define HBP_EISA_DATA_W     32
`define HBP_ADDR_HI         15
`define HBP_ADDR_LO         2
`define HBP_DECODE_LO       4
`define HBP_BASE_RESET      12'h030
`define HBP_IO_MIN_NS       180
`define HBP_CLK_NS          10
`define HBP_IO_MIN_CYC      ((`HBP_IO_MIN_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`define HBP_REG_WORDS       16
`define HBP_REG_AW          4
`endif

// ### verilog/hbp_pkg.sv
// Types for the ISA/EISA host bus port
package hbp_pkg;
  typedef enum logic [3:0] {
    HBP_IDLE  = 4'b0001,
    HBP_READ  = 4'b0010,
    HBP_WRITE = 4'b0100,
    HBP_DMA   = 4'b1000
  } hbp_state_t;
endpackage

// ### verilog/hbp_regmem.sv
// Small register store behind the host port, registered read data
`timescale 1ns/1ps
module hbp_regmem #(
  parameter int WORDS = 16,
  parameter int AW    = 4
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [3:0]    be_i,
  input  wire logic [31:0]   wdata_i,
  output logic      [31:0]   rdata_o
);
  logic [31:0] mem [WORDS];

  always_ff @(posedge clk_i) begin
    for (int b = 0; b < 4; b++) begin
      if (we_i && be_i[b]) begin
        mem[addr_i][8*b +: 8] <= wdata_i[8*b +: 8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem[addr_i];
  end
endmodule

// ### verilog/hbp_port.sv
// Host bus slave port: strobes, lanes, address latch, select, burst DMA
`timescale 1ns/1ps
`include "hbp_map.svh"

// How it works
// - ISA: sixteen-bit path, lanes by two enables
// - EISA: thirty-two-bit slave plus burst DMA
// - I/O accesses long enough, no waits
// - Burst DMA takes one doubleword per clock
// - Wait state request holds off DMA
// - Address latch transparent low, holds after rise
// - AEN latch transparent low, holds after rise
// - Push-pull select on A15..A4 match, AEN low
// - Write data captured on write strobe trailing edge
module hbp_port
  import hbp_pkg::*;
#(
  parameter logic [11:0] BASE_ADDR = `HBP_BASE_RESET,
  parameter int          WORDS     = `HBP_REG_WORDS
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        eisa_mode_i,
  input  wire logic [15:2] register_address_bits_i,
  input  wire logic        aen_i,
  input  wire logic        address_strobe_low_i,
  input  wire logic        read_strobe_low_i,
  input  wire logic        write_strobe_low_i,
  input  wire logic        byte_lane0_enable_low_i,
  input  wire logic        byte_lane1_enable_low_i,
  input  wire logic        byte_lane2_enable_low_i,
  input  wire logic        byte_lane3_enable_low_i,
  input  wire logic [31:0] data_i,
  input  wire logic        dma_req_i,
  input  wire logic        exrdy_i,
  output logic      [31:0] data_o,
  output logic      [3:0]  data_oe_o,
  output logic             local_device_select_low_o,
  output logic             dma_ack_o,
  output logic      [31:0] dma_data_o,
  output logic             dma_valid_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage read only by the second
  logic [25:0] sync1;
  logic [25:0] sync2;
  logic [25:0] pins;
  assign pins = {register_address_bits_i, aen_i, address_strobe_low_i, read_strobe_low_i,
                 write_strobe_low_i, byte_lane3_enable_low_i, byte_lane2_enable_low_i,
                 byte_lane1_enable_low_i, byte_lane0_enable_low_i, dma_req_i, exrdy_i,
                 eisa_mode_i, 1'b0};
  // Reset to the idle pin levels so no false strobe edge follows reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1 <= 26'h0000ff4;
      sync2 <= 26'h0000ff4;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  // Data pins cross the same two stages so they stay aligned with the strobes
  logic [31:0] data_sync1;
  logic [31:0] s_data;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_sync1 <= 32'h0;
      s_data     <= 32'h0;
    end else begin
      data_sync1 <= data_i;
      s_data     <= data_sync1;
    end
  end

  logic [15:2] s_addr;
  logic        s_aen, s_ads_n, s_rd_n, s_wr_n, s_req, s_rdy, s_eisa;
  logic [3:0]  s_be_n;
  assign s_addr  = sync2[25:12];
  assign s_aen   = sync2[11];
  assign s_ads_n = sync2[10];
  assign s_rd_n  = sync2[9];
  assign s_wr_n  = sync2[8];
  assign s_be_n  = sync2[7:4];
  assign s_req   = sync2[3];
  assign s_rdy   = sync2[2];
  assign s_eisa  = sync2[1];

  ////////////////////////////////////////////////////////////////////////////
  // Address, AEN and byte-enable latches
  logic        ads_d, rd_d, wr_d;
  logic [15:2] lat_addr;
  logic        lat_aen;
  logic [3:0]  lat_be_n;
  logic        aen_eff;
  logic [3:0]  be_eff;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ads_d <= 1'b1;
      rd_d  <= 1'b1;
      wr_d  <= 1'b1;
    end else begin
      ads_d <= s_ads_n;
      rd_d  <= s_rd_n;
      wr_d  <= s_wr_n;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lat_addr <= 14'h0;
      lat_aen  <= 1'b1;
      lat_be_n <= 4'hf;
    end else if (!s_ads_n) begin
      lat_addr <= s_addr;
      lat_aen  <= s_aen;
      lat_be_n <= s_be_n;
    end
  end

  // ISA ties the address strobe low, so the latch stays open there
  assign aen_eff = s_ads_n ? lat_aen : s_aen;

  function automatic logic [3:0] lanes(input logic eisa, input logic [3:0] be_n);
    lanes = eisa ? ~be_n : {2'b00, ~be_n[1:0]};
  endfunction
  assign be_eff = lanes(s_eisa, s_ads_n ? lat_be_n : s_be_n);

  ////////////////////////////////////////////////////////////////////////////
  // Device select
  logic decode_hit;
  assign decode_hit = (lat_addr[15:4] == BASE_ADDR) && !aen_eff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      local_device_select_low_o <= 1'b1;
    end else begin
      local_device_select_low_o <= !decode_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencing
  hbp_state_t state;
  logic       rd_fall, wr_rise;
  logic       mem_we;
  logic [31:0] mem_rdata;
  logic [`HBP_REG_AW-1:0] mem_addr;
  logic [`HBP_REG_AW-1:0] dma_ptr;
  assign rd_fall = rd_d && !s_rd_n;
  assign wr_rise = !wr_d && s_wr_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= HBP_IDLE;
    end else begin
      case (state)
        HBP_IDLE: begin
          if (s_req && s_eisa && s_rd_n && s_wr_n) begin
            state <= HBP_DMA;
          end else if (rd_fall && decode_hit) begin
            state <= HBP_READ;
          end else if (!s_wr_n && decode_hit) begin
            state <= HBP_WRITE;
          end
        end
        HBP_READ:  if (s_rd_n) state <= HBP_IDLE;
        HBP_WRITE: if (s_wr_n) state <= HBP_IDLE;
        HBP_DMA:   if (!s_req) state <= HBP_IDLE;
        default:   state <= HBP_IDLE;
      endcase
    end
  end

  // Strobe-timed accesses need no wait states
  assign mem_we   = (state == HBP_WRITE && wr_rise) || (state == HBP_DMA && s_rdy);
  assign mem_addr = (state == HBP_DMA) ? dma_ptr : lat_addr[`HBP_REG_AW+1:2];

  hbp_regmem #(.WORDS(WORDS), .AW(`HBP_REG_AW)) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .be_i    ((state == HBP_DMA) ? 4'hf : be_eff),
    .wdata_i (s_data),
    .rdata_o (mem_rdata)
  );

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dma_ptr <= '0;
    end else if (state != HBP_DMA) begin
      dma_ptr <= '0;
    end else if (s_rdy) begin
      dma_ptr <= dma_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dma_ack_o   <= 1'b0;
      dma_valid_o <= 1'b0;
      dma_data_o  <= 32'h0;
    end else begin
      dma_ack_o   <= (state == HBP_DMA);
      dma_valid_o <= (state == HBP_DMA) && s_rdy;
      dma_data_o  <= s_data;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_o    <= 32'h0;
      data_oe_o <= 4'h0;
    end else begin
      data_o    <= mem_rdata;
      data_oe_o <= (state == HBP_READ && !s_rd_n) ? be_eff : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_isa_upper_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !s_eisa |-> data_oe_o[3:2] == 2'b00) else $error("ISA drove upper lanes");
  a_select_decode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    lat_addr[15:4] != BASE_ADDR |=> local_device_select_low_o) else $error("Select off base");
  a_aen_blocks: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_ads_n && lat_aen |=> local_device_select_low_o) else $error("Select with AEN high");
  a_addr_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_ads_n && $past(s_ads_n) |-> $stable(lat_addr)) else $error("Address changed");
  a_dma_rate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == HBP_DMA && s_rdy |=> dma_valid_o) else $error("Missed DMA word");
  a_dma_wait: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == HBP_DMA && !s_rdy |=> !dma_valid_o && $stable(dma_ptr)) else $error("DMA ran");
  a_write_edge: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == HBP_WRITE && mem_we |-> s_wr_n && !wr_d) else $error("Write off edge");
  a_read_lanes: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == HBP_READ && !s_rd_n |=> data_oe_o == $past(be_eff)) else $error("Bad lanes");
  c_read:  cover property (@(posedge clk_i) state == HBP_READ);
  c_write: cover property (@(posedge clk_i) state == HBP_WRITE ##1 state == HBP_IDLE);
  c_dma:   cover property (@(posedge clk_i) dma_valid_o [*3]);
endmodule

// ### verification/hbp_host_model.sv
// Host bus master and glue model: strobes, address, AEN and burst pacing
`timescale 1ns/1ps
module hbp_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [3:0]  roe_i,
  input  wire logic        sel_n_i,
  output logic             eisa_o,
  output logic [15:2]      addr_o,
  output logic             aen_o,
  output logic             ads_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic [3:0]       be_n_o,
  output logic [31:0]      data_o,
  output logic             req_o,
  output logic             rdy_o
);
  initial begin
    {eisa_o, aen_o, ads_n_o, rd_n_o, wr_n_o, be_n_o} = 9'h1ff;
    addr_o = 14'h0;
    data_o = 32'h0;
    req_o  = 1'b0;
    rdy_o  = 1'b1;
  end
  task automatic rest(input int n);
    aen_o   = 1'b1;
    ads_n_o = eisa_o;
    addr_o  = ~addr_o;
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic mode(input logic e);
    eisa_o = e;
    rest(5);
  endtask
  task automatic go(input logic [1:0] i, input logic [3:0] be, input logic miss);
    addr_o  = {12'h030 ^ {11'h0, miss}, i};
    be_n_o  = be;
    aen_o   = 1'b0;
    ads_n_o = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 ads_n_o = eisa_o;
    // Pins wander after the strobe, so only latched values may decode
    if (eisa_o) begin
      addr_o = ~addr_o;
      aen_o  = 1'b1;
    end
  endtask
  task automatic wr(input logic [1:0] i, input logic [3:0] be, input logic [31:0] d);
    data_o = d;
    go(i, be, 1'b0);
    wr_n_o = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 wr_n_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 data_o = ~d;
    rest(5);
  endtask
  task automatic rd(input logic [1:0] i, input logic [3:0] be, input logic miss,
                    output logic [31:0] d, output logic [3:0] oe, output logic s);
    go(i, be, miss);
    rd_n_o = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 d = rdata_i;
    oe     = roe_i;
    s      = sel_n_i;
    rd_n_o = 1'b1;
    rest(5);
  endtask
  task automatic dma(input logic r, input logic y, input logic [31:0] d);
    data_o = d;
    req_o  = r;
    rdy_o  = y;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
  endtask
endmodule

// ### verification/isa_eisa_host_bus_port_bench.sv
// Self-checking bench for the host bus port against the host model
`timescale 1ns/1ps
module isa_eisa_host_bus_port_bench;
  logic        clk_i, reset_n_i, eisa, aen, ads_n, rd_n, wr_n, req, rdy, sel_n, ack, vld, s;
  logic [15:2] addr;
  logic [3:0]  be_n, oe, o, bv;
  logic [1:0]  idx;
  logic [31:0] wdata, rdata, ddata, dword, word, d;
  logic [31:0] shadow [4];
  int          bad_count, num_checks, cycles, vcount, v0;
  hbp_port i_hbp_port (.clk_i(clk_i), .reset_n_i(reset_n_i), .eisa_mode_i(eisa),
    .register_address_bits_i(addr), .aen_i(aen), .address_strobe_low_i(ads_n),
    .read_strobe_low_i(rd_n), .write_strobe_low_i(wr_n), .byte_lane0_enable_low_i(be_n[0]),
    .byte_lane1_enable_low_i(be_n[1]), .byte_lane2_enable_low_i(be_n[2]),
    .byte_lane3_enable_low_i(be_n[3]), .data_i(wdata), .dma_req_i(req), .exrdy_i(rdy),
    .data_o(rdata), .data_oe_o(oe), .local_device_select_low_o(sel_n), .dma_ack_o(ack),
    .dma_data_o(ddata), .dma_valid_o(vld));
  hbp_host_model i_hbp_host_model (.clk_i(clk_i), .rdata_i(rdata), .roe_i(oe),
    .sel_n_i(sel_n), .eisa_o(eisa), .addr_o(addr), .aen_o(aen), .ads_n_o(ads_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .be_n_o(be_n), .data_o(wdata), .req_o(req), .rdy_o(rdy));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [3:0] lanes(input logic [3:0] be);
    lanes = eisa ? ~be : {2'b00, ~be[1:0]};
  endfunction
  task automatic put(input logic [1:0] i, input logic [3:0] be);
    logic [3:0] l;
    l    = lanes(be);
    word = $urandom();
    i_hbp_host_model.wr(i, be, word);
    for (int k = 0; k < 4; k++) if (l[k]) shadow[i][8*k +: 8] = word[8*k +: 8];
  endtask
  task automatic get(input logic [1:0] i, input logic [3:0] be);
    logic [31:0] m;
    logic [3:0]  l;
    l = lanes(be);
    for (int k = 0; k < 4; k++) m[8*k +: 8] = {8{l[k]}};
    i_hbp_host_model.rd(i, be, 1'b0, d, o, s);
    check({28'h0, o}, {28'h0, l});
    check(d & m, shadow[i] & m);
    check({31'h0, s}, 32'h0);
  endtask
  // Negedge sampling keeps the monitor clear of the design's own edge
  always @(negedge clk_i) begin
    cycles++;
    if (vld === 1'b1) begin
      vcount++;
      check(ddata, dword);
    end
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n_i = 1'b0;
    dword     = 32'h0;
    void'($urandom(32'h052c));
    repeat (10) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    for (int i = 0; i < 4; i++) put(i[1:0], 4'h0);
    for (int i = 0; i < 4; i++) get(i[1:0], 4'h0);
    repeat (6) begin
      bv  = 4'($urandom());
      idx = 2'($urandom());
      put(idx, bv);
      get(idx, 4'h0);
    end
    i_hbp_host_model.rd(2'h1, 4'h0, 1'b1, d, o, s);
    check({28'h0, o}, 32'h0);
    check({31'h0, s}, 32'h1);
    i_hbp_host_model.mode(1'b0);
    for (int k = 0; k < 3; k++) begin
      idx = 2'($urandom());
      put(idx, 4'hc | k[1:0]);
      get(idx, 4'hc | k[1:0]);
    end
    i_hbp_host_model.dma(1'b1, 1'b1, dword);
    repeat (10) @(posedge clk_i);
    #1 check({31'h0, ack}, 32'h0);
    i_hbp_host_model.dma(1'b0, 1'b1, dword);
    i_hbp_host_model.mode(1'b1);
    dword = $urandom();
    i_hbp_host_model.dma(1'b1, 1'b1, dword);
    repeat (8) @(posedge clk_i);
    #1 v0 = vcount;
    repeat (16) @(posedge clk_i);
    #1 check(vcount - v0, 32'd16);
    check({31'h0, ack}, 32'h1);
    i_hbp_host_model.dma(1'b1, 1'b0, dword);
    repeat (4) @(posedge clk_i);
    #1 v0 = vcount;
    repeat (10) @(posedge clk_i);
    #1 check(vcount - v0, 32'd0);
    i_hbp_host_model.dma(1'b0, 1'b1, dword);
    repeat (10) @(posedge clk_i);
    wrap_up();
  end
endmodule
